// file: rtl/drsc_image_mem.sv
// image memory: 16 bytes per row by 64 rows, one write and one read port.
// assumes one clock; read data appears one edge after the address.
`timescale 1ns/1ns
`include "drsc_regs.svh"

module drsc_image_mem
#(
	parameter int ADDR_W = `DRSC_MEM_ADDR_W,
	parameter int DATA_W = 8
)
(
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data
);

	// contents survive reset, as software reset leaves the image alone
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] next_rd_data;

	always_comb
	begin
		next_rd_data = mem[rd_addr];
	end

	// array write; no reset so it maps onto block ram
	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read port
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rd_data <= '0;
		end
		else
		begin
			rd_data <= next_rd_data;
		end
	end

endmodule

// file: rtl/drsc_pkg.sv
// types shared by the refresh origin and scroll block.
// assumes drsc_regs.svh is on the include path.
`include "drsc_regs.svh"

package drsc_pkg;

	// one decoded command byte with its parameter byte
	typedef struct packed {
		logic                       valid;
		logic [7:0]                 code;
		logic [7:0]                 param;
	} drsc_cmd_t;

	// image memory write port, one byte per beat
	typedef struct packed {
		logic                       valid;
		logic [`DRSC_MEM_ADDR_W-1:0] addr;
		logic [7:0]                 data;
	} drsc_memwr_t;

	// one refreshed pixel towards the panel driver
	typedef struct packed {
		logic                       valid;
		logic                       frame_start;
		logic                       data;
		logic [`DRSC_COL_W-1:0]     col;
		logic [`DRSC_ROW_W-1:0]     row;
	} drsc_pix_t;

	// software-visible settings
	typedef struct packed {
		logic [`DRSC_SCAN_ORDER_W-1:0] scan_order;
		logic [`DRSC_COL_W-1:0]     start_col;
		logic [`DRSC_ROW_W-1:0]     start_row;
		logic [`DRSC_COUNT_W-1:0]   step_count;
		logic [`DRSC_UNIT_W-1:0]    step_unit;
		logic                       scroll_leftward;
		logic                       scroll_en;
	} drsc_cfg_t;

	typedef enum logic [0:0] {
		DRSC_GAP    = 1'b0,
		DRSC_ACTIVE = 1'b1
	} drsc_scan_t;

	// whole state of the refresh controller
	typedef struct packed {
		drsc_cfg_t                  cfg;
		logic [`DRSC_COL_W-1:0]     scroll_ofs;
		drsc_scan_t                 scan;
		logic [`DRSC_COL_W-1:0]     col;
		logic [`DRSC_ROW_W-1:0]     row;
		logic [`DRSC_COL_W-1:0]     frame_col;
		logic [`DRSC_ROW_W-1:0]     frame_row;
		logic                       frame_bot_up;
		logic                       rd_pend;
		logic                       rd_first;
		logic [2:0]                 rd_bit;
		logic [`DRSC_COL_W-1:0]     rd_col;
		logic [`DRSC_ROW_W-1:0]     rd_row;
		drsc_pix_t                  pix;
	} drsc_state_t;

endpackage

// file: rtl/drsc_refresh_ctrl.sv
// refresh origin and screen-saver scroll control with its image memory.
// assumes commands arrive already deframed from the serial command link,
// one code with its parameter per valid beat, synchronous to clk_sys.
//
// Functional notes
// - command 09 loads the two-bit order used to scan memory out
// - order 00 scans rows top down, order 10 scans rows bottom up
// - command 38 sets horizontal start bit, 0 to 127
// - command 39 sets vertical start row, 0 to 63
// - each refresh reads 96 bits by 64 rows from the start point
// - reading wraps from bit 127 to bit 0 and row 63 to row 0
// - new start positions take effect only at the next refresh
// - screen saver scrolls the 128 bit wide image through the window
// - command C3 loads step count, with zero meaning 256
// - command C4 unit: 01 is 1 ms, 10 is 100 ms, else stopped
// - command CC bit 0 picks scroll direction, 1 means leftward
// - command CD bit 0 enables the screen-saver scroll
// - enable with a stopped timer gives no scrolling
// - disabling the scroll returns to the programmed start
// - image memory is 16 bytes per row by 64 rows
// - software reset command 01 clears every setting to zero
`timescale 1ns/1ns
`include "drsc_regs.svh"

module drsc_refresh_ctrl
#(
	parameter int MS_CYCLES    = `DRSC_MS_CYCLES,
	parameter int COARSE_TICKS = `DRSC_COARSE_TICKS
)
(
	input  wire logic                    clk_sys,
	input  wire logic                    reset,
	input  wire drsc_pkg::drsc_cmd_t     cmd,
	input  wire drsc_pkg::drsc_memwr_t   mem_wr,
	output drsc_pkg::drsc_pix_t          pix,
	output logic [`DRSC_COL_W-1:0]       live_start_col,
	output logic [`DRSC_ROW_W-1:0]       live_start_row,
	output logic [`DRSC_COL_W-1:0]       scroll_offset
);

	import drsc_pkg::*;

	// timing of one frame, in clk_sys cycles:
	// gap cycle: origin, offset and scan order are latched for the frame
	// active cycles: one panel pixel per cycle, 96 per row, 64 rows
	// cycle a: address of pixel a goes to the image memory
	// cycle a+1: memory byte of pixel a is ready, bit picked by rd_bit
	// cycle a+2: pixel a stands on pix for one cycle
	// so a frame lasts 6145 cycles and pix is idle for one of them
	//
	// horizontal position wraps modulo 128 and vertical modulo 64 simply
	// because the sums are kept at the width of the memory coordinates
	//
	// scroll offset lives beside the settings, not inside them, so that
	// disabling the saver brings back the programmed start unchanged;
	// the offset is added to the start column only at the gap latch
	//
	// limitation: a setting taken at the edge into the gap cycle is used
	// for the coming frame; one taken at the edge after it waits a frame
	//
	// hazard: image bytes written during a frame may show partly in that
	// frame, as the memory has no second bank
	//
	// reset clears settings, offset and the pixel output; the image
	// memory keeps its contents, as does a software reset

	// whole controller state and its next value
	drsc_state_t                 st;
	drsc_state_t                 next_st;

	// step timer hand-off
	logic                        timer_run;
	logic                        step_pulse;

	// image memory read port
	logic [`DRSC_MEM_ADDR_W-1:0] rd_addr;
	logic [7:0]                  rd_data;

	// memory coordinates of the pixel being addressed
	logic [`DRSC_COL_W-1:0]      mem_x;
	logic [`DRSC_ROW_W-1:0]      scan_y;
	logic [`DRSC_ROW_W-1:0]      mem_y;

	// byte address of a bit position: row times 16 plus byte in row
	function automatic logic [`DRSC_MEM_ADDR_W-1:0] drsc_addr(
		input logic [`DRSC_COL_W-1:0] x,
		input logic [`DRSC_ROW_W-1:0] y
	);
		drsc_addr = {y, x[`DRSC_COL_W-1:3]};
	endfunction

	// leftmost pixel of a byte is its most significant bit
	function automatic logic drsc_bit(
		input logic [7:0] byte_in,
		input logic [2:0] pos
	);
		drsc_bit = byte_in[3'(3'h7 - pos)];
	endfunction

	// only the two running unit codes let the timer count
	function automatic logic drsc_unit_runs(input logic [1:0] unit);
		drsc_unit_runs = (unit == `DRSC_UNIT_FINE) ||
			(unit == `DRSC_UNIT_COARSE);
	endfunction

	// step timer runs only when enabled with a running unit
	assign timer_run = st.cfg.scroll_en &&
		drsc_unit_runs(st.cfg.step_unit);

	// screen-saver step timer, one pulse per expiry
	drsc_step_timer #(
		.MS_CYCLES    (MS_CYCLES),
		.COARSE_TICKS (COARSE_TICKS)
	) u_timer (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.run        (timer_run),
		.step_unit  (st.cfg.step_unit),
		.step_count (st.cfg.step_count),
		.step       (step_pulse)
	);

	// image memory, 16 bytes by 64 rows
	drsc_image_mem #(
		.ADDR_W (`DRSC_MEM_ADDR_W),
		.DATA_W (8)
	) u_mem (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr_en   (mem_wr.valid),
		.wr_addr (mem_wr.addr),
		.wr_data (mem_wr.data),
		.rd_addr (rd_addr),
		.rd_data (rd_data)
	);

	// memory coordinates of the current panel pixel; 7 and 6 bit sums
	// wrap by themselves, which gives the window its wrap-around
	assign mem_x = 7'(st.frame_col + st.col);
	assign scan_y = st.frame_bot_up ?
		6'(`DRSC_LAST_ROW - st.row) : st.row;
	assign mem_y = 6'(st.frame_row + scan_y);
	assign rd_addr = drsc_addr(mem_x, mem_y);

	// status taken straight from state flops
	assign pix = st.pix;
	assign live_start_col = st.frame_col;
	assign live_start_row = st.frame_row;
	assign scroll_offset = st.scroll_ofs;

	always_comb
	begin
		next_st = st;
		next_st.pix.valid = 1'b0;
		next_st.pix.frame_start = 1'b0;
		next_st.rd_pend = 1'b0;

		// scroll offset: cleared whenever the saver is off, so the
		// original window comes back on the next refresh
		if (!st.cfg.scroll_en)
		begin
			next_st.scroll_ofs = '0;
		end
		else if (step_pulse)
		begin
			// leftward moves the image left, so the start advances
			if (st.cfg.scroll_leftward)
			begin
				next_st.scroll_ofs = 7'(st.scroll_ofs + 1'b1);
			end
			else
			begin
				next_st.scroll_ofs = 7'(st.scroll_ofs - 1'b1);
			end
		end

		// command decode after the scroll so a software reset wins
		if (cmd.valid)
		begin
			case (cmd.code)
				// every setting and the offset back to zero
				`DRSC_CMD_SW_RESET:
				begin
					next_st.cfg.scan_order = `DRSC_RST_ORDER;
					next_st.cfg.start_col = `DRSC_RST_COL;
					next_st.cfg.start_row = `DRSC_RST_ROW;
					next_st.cfg.step_count = `DRSC_RST_COUNT;
					next_st.cfg.step_unit = `DRSC_RST_UNIT;
					next_st.cfg.scroll_leftward = `DRSC_RST_FLAG;
					next_st.cfg.scroll_en = `DRSC_RST_FLAG;
					next_st.scroll_ofs = '0;
				end
				// order used from the next frame on
				`DRSC_CMD_SCAN_ORDER:
				begin
					next_st.cfg.scan_order =
						cmd.param[`DRSC_SCAN_ORDER_W-1:0];
				end
				// horizontal start bit
				`DRSC_CMD_START_COL:
				begin
					// top bit of the parameter is out of range, dropped
					next_st.cfg.start_col = cmd.param[`DRSC_COL_W-1:0];
				end
				// vertical start row, upper bits dropped
				`DRSC_CMD_START_ROW:
				begin
					next_st.cfg.start_row = cmd.param[`DRSC_ROW_W-1:0];
				end
				// count used at the next timer reload
				`DRSC_CMD_STEP_COUNT:
				begin
					next_st.cfg.step_count = cmd.param;
				end
				// unit code, stopped codes halt the timer
				`DRSC_CMD_STEP_UNIT:
				begin
					next_st.cfg.step_unit = cmd.param[`DRSC_UNIT_W-1:0];
				end
				// direction of the next steps
				`DRSC_CMD_SCROLL_DIR:
				begin
					next_st.cfg.scroll_leftward =
						cmd.param[`DRSC_FLAG_BIT];
				end
				// saver on or off
				`DRSC_CMD_SCROLL_EN:
				begin
					next_st.cfg.scroll_en = cmd.param[`DRSC_FLAG_BIT];
				end
				default:
				begin
					// codes of other blocks are not ours; ignore them
					next_st.cfg = st.cfg;
				end
			endcase
		end

		// refresh scan: one gap cycle latches the origin, then one
		// pixel per clock; the latched origin and scan order never change inside a frame
		unique case (st.scan)
			// one idle cycle between frames
			DRSC_GAP:
			begin
				next_st.frame_col = 7'(st.cfg.start_col + st.scroll_ofs);
				next_st.frame_row = st.cfg.start_row;
				next_st.frame_bot_up =
					(st.cfg.scan_order == `DRSC_ORDER_BOTTOM_UP);
				next_st.col = '0;
				next_st.row = '0;
				next_st.scan = DRSC_ACTIVE;
			end
			// address one pixel per cycle
			DRSC_ACTIVE:
			begin
				next_st.rd_pend = 1'b1;
				next_st.rd_first = (st.col == '0) && (st.row == '0);
				next_st.rd_bit = mem_x[2:0];
				next_st.rd_col = st.col;
				next_st.rd_row = st.row;
				// last visible column ends a panel row
				if (st.col == `DRSC_VIS_LAST_COL)
				begin
					next_st.col = '0;
					// last row closes the frame
					if (st.row == `DRSC_LAST_ROW)
					begin
						next_st.row = '0;
						next_st.scan = DRSC_GAP;
					end
					else
					begin
						next_st.row = 6'(st.row + 1'b1);
					end
				end
				else
				begin
					next_st.col = 7'(st.col + 1'b1);
				end
			end
		endcase

		// pixel stage: memory answered the address of the last cycle
		if (st.rd_pend)
		begin
			next_st.pix.valid = 1'b1;
			next_st.pix.frame_start = st.rd_first;
			next_st.pix.data = drsc_bit(rd_data, st.rd_bit);
			next_st.pix.col = st.rd_col;
			next_st.pix.row = st.rd_row;
		end
	end

	// the whole controller state in one register
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

endmodule

// file: rtl/drsc_regs.svh
// command codes, field layouts, reset values and timing counts of the
// refresh origin and screen-saver scroll block.
// assumes a 250 MHz system clock; included by the package and modules.
`ifndef DRSC_REGS_SVH
`define DRSC_REGS_SVH

// command bytes
`define DRSC_CMD_SW_RESET     8'h01
`define DRSC_CMD_SCAN_ORDER   8'h09
`define DRSC_CMD_START_COL    8'h38
`define DRSC_CMD_START_ROW    8'h39
`define DRSC_CMD_STEP_COUNT   8'hC3
`define DRSC_CMD_STEP_UNIT    8'hC4
`define DRSC_CMD_SCROLL_DIR   8'hCC
`define DRSC_CMD_SCROLL_EN    8'hCD

// parameter field positions and widths
`define DRSC_SCAN_ORDER_W     2
`define DRSC_COL_W            7
`define DRSC_ROW_W            6
`define DRSC_UNIT_W           2
`define DRSC_COUNT_W          8
`define DRSC_FLAG_BIT         0

// field codes
`define DRSC_ORDER_BOTTOM_UP  2'h2
`define DRSC_UNIT_FINE        2'h1
`define DRSC_UNIT_COARSE      2'h2
`define DRSC_COUNT_ZERO_AS    9'h100

// reset values of every setting
`define DRSC_RST_ORDER        2'h0
`define DRSC_RST_COL          7'h00
`define DRSC_RST_ROW          6'h00
`define DRSC_RST_COUNT        8'h00
`define DRSC_RST_UNIT         2'h0
`define DRSC_RST_FLAG         1'h0

// image memory and refresh window geometry
`define DRSC_MEM_BYTES_ROW    16
`define DRSC_MEM_ROWS         64
`define DRSC_MEM_ADDR_W       10
`define DRSC_VIS_LAST_COL     7'h5F
`define DRSC_LAST_ROW         6'h3F

// timing: figures in their own units, counts derived from the clock
`define DRSC_CLK_PERIOD_NS    4
`define DRSC_FINE_STEP_NS     1000000
`define DRSC_FINE_STEP_MS     1
`define DRSC_COARSE_STEP_MS   100
`define DRSC_MS_CYCLES        (`DRSC_FINE_STEP_NS / `DRSC_CLK_PERIOD_NS)
`define DRSC_COARSE_TICKS     (`DRSC_COARSE_STEP_MS / `DRSC_FINE_STEP_MS)

`endif

// file: rtl/drsc_step_timer.sv
// screen-saver step timer: prescaler to 1 ms, unit of 1 or 100 ms,
// then an 8-bit count of units; one-cycle step pulse per expiry.
// assumes the settings are steady while run is high.
`timescale 1ns/1ns
`include "drsc_regs.svh"

module drsc_step_timer
#(
	parameter int MS_CYCLES    = `DRSC_MS_CYCLES,
	parameter int COARSE_TICKS = `DRSC_COARSE_TICKS
)
(
	input  wire logic                     clk_sys,
	input  wire logic                     reset,
	input  wire logic                     run,
	input  wire logic [`DRSC_UNIT_W-1:0]  step_unit,
	input  wire logic [`DRSC_COUNT_W-1:0] step_count,
	output logic                          step
);

	localparam int PW = $clog2(MS_CYCLES + 1);
	localparam int TW = $clog2(COARSE_TICKS + 1);

	typedef struct packed {
		logic [PW-1:0] pre;
		logic [TW-1:0] ticks;
		logic [8:0]    left;
		logic          step;
	} drsc_tmr_st_t;

	drsc_tmr_st_t st;
	drsc_tmr_st_t next_st;
	logic         unit_done;

	// zero means a full 256 units
	function automatic logic [8:0] drsc_reload(input logic [7:0] cnt);
		drsc_reload = (cnt == 8'h00) ? `DRSC_COUNT_ZERO_AS : {1'b0, cnt};
	endfunction

	assign step = st.step;

	// prescale, unit and count chain
	always_comb
	begin
		next_st = st;
		next_st.step = 1'b0;
		unit_done = 1'b0;
		if (!run)
		begin
			// stopped timer restarts from a full count
			next_st.pre = '0;
			next_st.ticks = '0;
			next_st.left = drsc_reload(step_count);
		end
		else if (st.pre == PW'(MS_CYCLES - 1))
		begin
			next_st.pre = '0;
			if (step_unit == `DRSC_UNIT_FINE)
			begin
				unit_done = 1'b1;
			end
			else if (st.ticks == TW'(COARSE_TICKS - 1))
			begin
				unit_done = 1'b1;
				next_st.ticks = '0;
			end
			else
			begin
				next_st.ticks = TW'(st.ticks + 1'b1);
			end
			if (unit_done)
			begin
				if (st.left == 9'h001)
				begin
					next_st.step = 1'b1;
					next_st.left = drsc_reload(step_count);
				end
				else
				begin
					next_st.left = 9'(st.left - 1'b1);
				end
			end
		end
		else
		begin
			next_st.pre = PW'(st.pre + 1'b1);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

endmodule

// file: verif/drsc_host_model.sv
// host side of the command link: deframed commands and image bytes.
// assumes clk_sys is shared with the block; drives on the falling edge.
`timescale 1ns/1ns
`include "drsc_regs.svh"

module drsc_host_model
	import drsc_pkg::*;
(
	input  wire logic     clk_sys,
	output drsc_pkg::drsc_cmd_t   cmd,
	output drsc_pkg::drsc_memwr_t mem_wr
);
	// lines start at zero; between beats they carry the inverse so stale data never looks valid
	initial
	begin
		cmd = '0;
		mem_wr = '0;
	end

	// one beat per command, code and parameter together
	task automatic send(input logic [7:0] code, input logic [7:0] param);
		@(negedge clk_sys);
		cmd <= '{1'b1, code, param};
		@(negedge clk_sys);
		cmd <= '{1'b0, ~code, ~param};
	endtask

	// only the two documented scan orders are ever sent
	task automatic send_order(input logic bottom_up);
		send(`DRSC_CMD_SCAN_ORDER, {6'h00, bottom_up, 1'b0});
	endtask

	task automatic write_byte(input logic [9:0] addr, input logic [7:0] data);
		@(negedge clk_sys);
		mem_wr <= '{1'b1, addr, data};
		@(negedge clk_sys);
		mem_wr <= '{1'b0, ~addr, ~data};
	endtask
endmodule

// file: verif/drsc_refresh_ctrl_properties.sv
// timing checks on the refresh output and scroll offset ports.
// assumes one clock domain; attached to the block by the bind below.
`timescale 1ns/1ns
`include "drsc_regs.svh"

module drsc_refresh_ctrl_properties
	import drsc_pkg::*;
#(
	parameter int MS_CYCLES    = 4,
	parameter int COARSE_TICKS = 3
)
(
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire drsc_pkg::drsc_cmd_t   cmd,
	input  wire drsc_pkg::drsc_memwr_t mem_wr,
	input  wire drsc_pkg::drsc_pix_t   pix,
	input  wire logic [6:0]            live_start_col,
	input  wire logic [5:0]            live_start_row,
	input  wire logic [6:0]            scroll_offset
);
	logic [12:0] run_len;

	// length of the current run of valid pixels
	always_ff @(posedge clk_sys)
	begin
		if (reset || !pix.valid)
			run_len <= 13'h0000;
		else
			run_len <= run_len + 13'h0001;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_frame_open;
		pix.valid && pix.frame_start && pix.col == 7'h00 && pix.row == 6'h00;
	endsequence
	sequence s_cmd(logic [7:0] code);
		cmd.valid && cmd.code == code;
	endsequence

	property p_gap_one;
		$fell(pix.valid) |=> s_frame_open;
	endproperty
	a_gap_one: assert property (p_gap_one)
		else $error("gap not followed by frame start");
	property p_frame_len;
		$fell(pix.valid) |-> run_len == 13'h1800;
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("frame length wrong");
	property p_col_step;
		pix.valid && $past(pix.valid) && $past(pix.col) != 7'h5F |->
			pix.col == $past(pix.col) + 7'h01 && pix.row == $past(pix.row);
	endproperty
	a_col_step: assert property (p_col_step)
		else $error("column order wrong");
	property p_row_next;
		pix.valid && $past(pix.valid) && $past(pix.col) == 7'h5F |->
			pix.col == 7'h00 && pix.row == $past(pix.row) + 6'h01;
	endproperty
	a_row_next: assert property (p_row_next)
		else $error("row order wrong");
	property p_origin_latch;
		$changed(live_start_col) || $changed(live_start_row) |->
			##[1:3] pix.frame_start;
	endproperty
	a_origin_latch: assert property (p_origin_latch)
		else $error("origin changed inside a frame");
	property p_disable_clear;
		s_cmd(`DRSC_CMD_SCROLL_EN) ##0 !cmd.param[0] |=>
			##1 scroll_offset == 7'h00;
	endproperty
	a_disable_clear: assert property (p_disable_clear)
		else $error("offset kept after disable");
	property p_swreset_clear;
		s_cmd(`DRSC_CMD_SW_RESET) |=> scroll_offset == 7'h00;
	endproperty
	a_swreset_clear: assert property (p_swreset_clear)
		else $error("offset kept after software reset");
	property p_step_one;
		$changed(scroll_offset) |-> scroll_offset == 7'h00 ||
			7'(scroll_offset - $past(scroll_offset)) inside {7'h01, 7'h7F};
	endproperty
	a_step_one: assert property (p_step_one)
		else $error("scroll step not one bit");
endmodule

bind drsc_refresh_ctrl drsc_refresh_ctrl_properties #(
	.MS_CYCLES(MS_CYCLES), .COARSE_TICKS(COARSE_TICKS)) chk_u (
	.clk_sys(clk_sys), .reset(reset), .cmd(cmd), .mem_wr(mem_wr),
	.pix(pix), .live_start_col(live_start_col),
	.live_start_row(live_start_row), .scroll_offset(scroll_offset));

// file: verif/test_drsc_refresh_ctrl.sv
// self-checking bench of the refresh origin and scroll block.
// assumes short timer counts: 4 cycles per ms, 3 ms per coarse unit.
`timescale 1ns/1ns
`include "drsc_regs.svh"

module test_drsc_refresh_ctrl;
	import drsc_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	drsc_cmd_t   cmd;
	drsc_memwr_t mem_wr;
	drsc_pix_t   pix;
	logic [6:0]  live_start_col;
	logic [5:0]  live_start_row;
	logic [6:0]  scroll_offset;
	int          cyc = 0;
	int          err_count = 0;
	int          n_tests = 0;

	drsc_host_model host_u (.clk_sys(clk_sys), .cmd(cmd), .mem_wr(mem_wr));
	drsc_refresh_ctrl #(.MS_CYCLES(4), .COARSE_TICKS(3)) dut_u (
		.clk_sys(clk_sys), .reset(reset), .cmd(cmd), .mem_wr(mem_wr),
		.pix(pix), .live_start_col(live_start_col),
		.live_start_row(live_start_row), .scroll_offset(scroll_offset));

	// 4 ns clock and a cycle count for timer gaps
	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;

	task automatic close_out();
		if (err_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	// a bound that runs out ends the run as a failure
	task automatic give_up(input int i, input int lim);
		if (i >= lim)
		begin
			err_count++;
			close_out();
		end
	endtask

	function automatic logic [7:0] pat(input int a);
		return 8'(a * 37 + (a >> 4));
	endfunction

	// expected pixel k of a frame from origin and scan order
	function automatic logic exp_pix(input logic [6:0] c0,
		input logic [5:0] r0, input logic bu, input int k);
		logic [6:0] x;
		logic [5:0] y;
		logic [7:0] b;
		x = c0 + 7'(k % 96);
		y = r0 + (bu ? 6'h3F - 6'(k / 96) : 6'(k / 96));
		b = pat({y, x[6:3]});
		return b[3'h7 - x[2:0]];
	endfunction

	task automatic wait_frame();
		int i;
		@(negedge clk_sys);
		for (i = 0; i < 7000 && pix.frame_start !== 1'b1; i++)
			@(negedge clk_sys);
		give_up(i, 7000);
	endtask

	task automatic check_frame(input logic [6:0] c0, input logic [5:0] r0,
		input logic bu);
		int k;
		logic b;
		wait_frame();
		check(16'(live_start_col), 16'(c0));
		check(16'(live_start_row), 16'(r0));
		for (k = 0; k < 6144; k++)
		begin
			b = exp_pix(c0, r0, bu, k);
			check(16'(pix.data), 16'(b));
			@(negedge clk_sys);
		end
	endtask

	task automatic wait_step();
		logic [6:0] last;
		int i;
		last = scroll_offset;
		for (i = 0; i < 2000 && scroll_offset === last; i++)
			@(negedge clk_sys);
		give_up(i, 2000);
	endtask

	task automatic step_gap(input int want, input logic [6:0] delta);
		logic [6:0] prev;
		int t0;
		wait_step();
		prev = scroll_offset;
		t0 = cyc;
		wait_step();
		check(16'(cyc - t0), 16'(want));
		check(16'(7'(scroll_offset - prev)), 16'(delta));
	endtask

	task automatic t_reset_fill();
		int a;
		check(16'({live_start_col, live_start_row}), 16'h0000);
		check(16'(scroll_offset), 16'h0000);
		for (a = 0; a < 1024; a++)
			host_u.write_byte(10'(a), pat(a));
		check_frame(7'h00, 6'h00, 1'b0);
	endtask

	// origin near the right and bottom edges forces both wraps
	task automatic t_origin();
		wait_frame();
		host_u.send(`DRSC_CMD_START_COL, 8'hFA);
		host_u.send(`DRSC_CMD_START_ROW, 8'h3E);
		check(16'(live_start_col), 16'h0000);
		check_frame(7'h7A, 6'h3E, 1'b0);
		wait_frame();
		host_u.send_order(1'b1);
		check_frame(7'h7A, 6'h3E, 1'b1);
	endtask

	task automatic t_scroll();
		logic [6:0] off;
		host_u.send_order(1'b0);
		host_u.send(`DRSC_CMD_START_COL, 8'h10);
		host_u.send(`DRSC_CMD_START_ROW, 8'h00);
		host_u.send(`DRSC_CMD_STEP_COUNT, 8'h02);
		host_u.send(`DRSC_CMD_STEP_UNIT, 8'h01);
		host_u.send(`DRSC_CMD_SCROLL_DIR, 8'h01);
		host_u.send(`DRSC_CMD_SCROLL_EN, 8'h01);
		step_gap(8, 7'h01);
		host_u.send(`DRSC_CMD_STEP_COUNT, 8'h00);
		step_gap(1024, 7'h01);
		// stop the timer so the new count and unit start cleanly
		host_u.send(`DRSC_CMD_STEP_UNIT, 8'h00);
		host_u.send(`DRSC_CMD_STEP_COUNT, 8'h01);
		host_u.send(`DRSC_CMD_STEP_UNIT, 8'h02);
		host_u.send(`DRSC_CMD_SCROLL_DIR, 8'h00);
		step_gap(12, 7'h7F);
		host_u.send(`DRSC_CMD_STEP_UNIT, 8'h00);
		off = scroll_offset;
		repeat (100) @(negedge clk_sys);
		check(16'(scroll_offset), 16'(off));
		check_frame(7'h10 + off, 6'h00, 1'b0);
		wait_frame();
		host_u.send(`DRSC_CMD_SCROLL_EN, 8'h00);
		// offset clears one cycle after the enable drops
		@(negedge clk_sys);
		check(16'(scroll_offset), 16'h0000);
		check_frame(7'h10, 6'h00, 1'b0);
	endtask

	// software reset, then enable with each stopped unit code
	task automatic t_swreset();
		// scroll running so the reset has an offset to clear
		host_u.send(`DRSC_CMD_STEP_UNIT, 8'h01);
		host_u.send(`DRSC_CMD_SCROLL_EN, 8'h01);
		repeat (20) @(negedge clk_sys);
		check(16'(scroll_offset == 7'h00), 16'h0000);
		wait_frame();
		host_u.send(`DRSC_CMD_SW_RESET, 8'h00);
		check(16'(scroll_offset), 16'h0000);
		check_frame(7'h00, 6'h00, 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			host_u.send(`DRSC_CMD_STEP_COUNT, 8'h01);
			host_u.send(`DRSC_CMD_STEP_UNIT, i == 0 ? 8'h00 : 8'h03);
			host_u.send(`DRSC_CMD_SCROLL_EN, 8'h01);
			repeat (200) @(negedge clk_sys);
			check(16'(scroll_offset), 16'h0000);
		end
	endtask

	initial
	begin
		repeat (20) @(negedge clk_sys);
		reset = 1'b0;
		t_reset_fill();
		t_origin();
		t_scroll();
		t_swreset();
		close_out();
	end
endmodule
